// File: rtl/gic_instruction_control.sv
// instruction decode and execution control of the serial guidance cpu
`default_nettype none

module gic_instruction_control #(
    parameter int CYCLE_CLKS = gic_pkg::CYCLE_CLKS, // clocks per operation cycle
    parameter int MPY_CLKS = gic_pkg::MPY_CLKS, // concurrent multiply time
    parameter int MPH_CLKS = gic_pkg::MPH_CLKS, // multiply and hold time
    parameter int DIV_CLKS = gic_pkg::DIV_CLKS // divide time
) (
    input wire logic clk_sys_i, // system clock
    input wire logic reset_n_i, // sync reset, active low
    output logic mem_rd_o, // memory read strobe
    output logic mem_wr_o, // memory write strobe
    output logic [3:0] mem_sector_o, // memory sector
    output logic mem_residual_o, // access residual memory
    output logic [7:0] mem_addr_o, // word address
    output logic [25:0] mem_wdata_o, // write data
    input wire logic [25:0] mem_rdata_i, // read data, next cycle
    output logic [2:0] mem_module_o, // memory module
    output logic mem_duplex_o, // duplex memory mode
    output logic mem_err_clear_o, // error latch clear pulse
    input wire logic [25:0] io_rdata_i, // io input word
    output logic io_out_o, // io output strobe
    output logic [8:0] io_addr_o, // io operand address
    output logic [25:0] io_wdata_o, // io output word
    input wire logic discrete_irq_i, // discrete interrupt pin
    input wire logic [25:0] timer_incr_i, // program-set timer increment
    input wire logic [25:0] timer_limit_i, // timer trip value
    output logic [25:0] acc_o, // accumulator
    output logic [25:0] pq_o, // product-quotient register
    output logic md_busy_o, // multiply/divide running
    output logic [7:0] icount_o // instruction counter
);
    typedef enum logic [3:0] {
        ST_FETCH, ST_FETCH_WAIT, ST_DECODE, ST_OPERAND, ST_EXEC, ST_WAIT, ST_IRQ_SAVE,
        ST_IRQ_HOP, ST_HOP_READ
    } gic_state_type;

    typedef struct packed {
        gic_state_type st;
        logic [31:0] cyc;
        logic [31:0] md_cnt;
        logic md_run;
        logic md_div;
        logic [25:0] md_a;
        logic [25:0] md_b;
        logic hold;
        logic [12:0] instr;
        logic [25:0] word;
        logic [25:0] acc;
        logic [25:0] pq;
        logic [7:0] icnt;
        logic syl;
        logic [3:0] isect;
        logic [3:0] dsect;
        logic [2:0] module_sel;
        logic duplex;
        logic err_clr;
        logic rd;
        logic wr;
        logic res;
        logic [3:0] sect;
        logic [7:0] addr;
        logic [25:0] wdata;
        logic io_out;
        logic [25:0] tsum;
        logic irq_pend;
        logic d1;
        logic d2;
        logic d3;
    } gic_regs_type;

    gic_regs_type r, n;
    logic [3:0] op;
    logic [8:0] oa;

    function automatic logic [25:0] md_result(input logic dv, input logic [25:0] a,
                                              input logic [25:0] b);
        logic [47:0] p;
        p = 48'($signed(a[25:2])) * 48'($signed(b[25:2]));
        if (dv) begin
            md_result = (b == 26'h0) ? 26'h0 : 26'($signed(a) / $signed(b));
        end else begin
            md_result = {p[46:23], 2'h0};
        end
    endfunction

    assign op = r.instr[3:0];
    assign oa = r.instr[12:4];

    always_comb begin
        n = r;
        n.rd = 1'b0;
        n.wr = 1'b0;
        n.err_clr = 1'b0;
        n.io_out = 1'b0;
        n.cyc = r.cyc + 32'h1;
        // multiply/divide element stops itself, result held
        if (r.md_run) begin
            n.md_cnt = r.md_cnt - 32'h1;
            if (r.md_cnt == 32'h1) begin
                n.md_run = 1'b0;
                if (r.hold) begin
                    n.acc = md_result(1'b0, r.md_a, r.md_b);
                    n.hold = 1'b0;
                end else begin
                    n.pq = md_result(r.md_div, r.md_a, r.md_b);
                end
            end
        end
        case (r.st)
            ST_FETCH: begin
                n.cyc = 32'h0;
                if (r.irq_pend) begin
                    n.st = ST_IRQ_SAVE;
                end else if (!r.hold) begin
                    n.rd = 1'b1;
                    n.res = 1'b0;
                    n.sect = r.isect;
                    n.addr = r.icnt;
                    n.icnt = r.syl ? r.icnt + 8'h1 : r.icnt;
                    n.syl = ~r.syl;
                    n.st = ST_FETCH_WAIT;
                end
            end
            ST_FETCH_WAIT: begin
                // read strobe is out this cycle, word arrives next
                n.st = ST_DECODE;
            end
            ST_DECODE: begin
                // syllable latch was already toggled at fetch
                n.instr = r.syl ? mem_rdata_i[25:13] : mem_rdata_i[12:0];
                n.st = ST_OPERAND;
            end
            ST_OPERAND: begin
                n.res = oa[gic_pkg::OPB_NINE];
                n.sect = r.dsect;
                n.addr = oa[7:0];
                n.rd = (op != gic_pkg::OP_STORE);
                n.st = ST_HOP_READ;
            end
            ST_EXEC: begin
                n.word = (r.res && r.addr == gic_pkg::RES_PQ_WORD) ? r.pq : mem_rdata_i;
                n.st = ST_WAIT;
                case (op)
                    gic_pkg::OP_SECTOR_JUMP: begin
                        n.isect = n.word[gic_pkg::SJ_ISECT_LSB +: 4];
                        n.icnt = n.word[gic_pkg::SJ_ICNT_LSB +: 8];
                        n.syl = n.word[gic_pkg::SJ_SYL_BIT];
                        n.dsect = n.word[gic_pkg::SJ_DSECT_LSB +: 4];
                        n.module_sel = n.word[gic_pkg::SJ_MOD_LSB +: 3];
                        n.duplex = n.word[gic_pkg::SJ_DUPLEX_BIT];
                        n.err_clr = n.word[gic_pkg::SJ_ERRCLR_BIT];
                    end
                    gic_pkg::OP_UNCOND_XFER: begin
                        n.icnt = oa[7:0];
                        n.syl = oa[gic_pkg::OPB_NINE];
                    end
                    gic_pkg::OP_TRANSFER_MINUS: begin
                        if (r.acc[25]) begin
                            n.icnt = oa[7:0];
                            n.syl = oa[gic_pkg::OPB_NINE];
                        end
                    end
                    gic_pkg::OP_TRANSFER_NZ: begin
                        if (r.acc != 26'h0) begin
                            n.icnt = oa[7:0];
                            n.syl = oa[gic_pkg::OPB_NINE];
                        end
                    end
                    gic_pkg::OP_SHIFT: begin
                        if (oa[gic_pkg::OPB_ONE]) begin
                            n.acc = 26'($signed(r.acc) >>> 1);
                        end else if (oa[gic_pkg::OPB_TWO]) begin
                            n.acc = 26'($signed(r.acc) >>> 2);
                        end else if (oa[gic_pkg::OPB_FIVE]) begin
                            n.acc = {r.acc[24:0], 1'b0};
                        end else if (oa[gic_pkg::OPB_SIX]) begin
                            n.acc = {r.acc[23:0], 2'h0};
                        end
                    end
                    gic_pkg::OP_LOGICAL_AND: n.acc = r.acc & n.word;
                    gic_pkg::OP_CLEAR_LOAD: n.acc = n.word;
                    gic_pkg::OP_ADD: n.acc = r.acc + n.word;
                    gic_pkg::OP_SUBTRACT: n.acc = r.acc - n.word;
                    gic_pkg::OP_XOR: n.acc = r.acc ^ n.word;
                    gic_pkg::OP_STORE: begin
                        n.wr = 1'b1;
                        n.wdata = r.acc;
                    end
                    gic_pkg::OP_CONC_MPY, gic_pkg::OP_MPY_HOLD, gic_pkg::OP_DIVIDE: begin
                        n.md_run = 1'b1;
                        n.md_div = (op == gic_pkg::OP_DIVIDE);
                        n.md_a = r.acc;
                        n.md_b = n.word;
                        n.hold = (op == gic_pkg::OP_MPY_HOLD);
                        n.md_cnt = (op == gic_pkg::OP_DIVIDE) ? DIV_CLKS :
                                   (op == gic_pkg::OP_MPY_HOLD) ? MPH_CLKS : MPY_CLKS;
                    end
                    gic_pkg::OP_PROCESS_IO: begin
                        // bits one/two: direction; eight: source on output, destination on input
                        if (oa[gic_pkg::OPB_ONE]) begin
                            n.io_out = 1'b1;
                            n.wdata = oa[gic_pkg::OPB_EIGHT] ? r.acc : n.word;
                        end else if (oa[gic_pkg::OPB_TWO]) begin
                            if (oa[gic_pkg::OPB_EIGHT]) begin
                                n.acc = io_rdata_i;
                            end else begin
                                n.wr = 1'b1;
                                n.wdata = io_rdata_i;
                            end
                        end
                    end
                    default: ;
                endcase
            end
            ST_WAIT: begin
                if (r.cyc >= 32'(CYCLE_CLKS - 1)) begin
                    n.st = ST_FETCH;
                end
            end
            ST_IRQ_SAVE: begin
                n.irq_pend = 1'b0;
                n.wr = 1'b1;
                n.res = 1'b1;
                n.addr = gic_pkg::RES_SAVE_WORD;
                n.wdata = 26'h0;
                n.wdata[gic_pkg::SJ_ISECT_LSB +: 4] = r.isect;
                n.wdata[gic_pkg::SJ_ICNT_LSB +: 8] = r.icnt;
                n.wdata[gic_pkg::SJ_SYL_BIT] = r.syl;
                n.wdata[gic_pkg::SJ_DSECT_LSB +: 4] = r.dsect;
                n.wdata[gic_pkg::SJ_MOD_LSB +: 3] = r.module_sel;
                n.wdata[gic_pkg::SJ_DUPLEX_BIT] = r.duplex;
                n.st = ST_IRQ_HOP;
            end
            ST_IRQ_HOP: begin
                n.rd = 1'b1;
                n.addr = gic_pkg::RES_HOP_CONST;
                n.instr = {1'b1, gic_pkg::RES_HOP_CONST, gic_pkg::OP_SECTOR_JUMP};
                n.st = ST_HOP_READ;
            end
            ST_HOP_READ: begin
                n.st = ST_EXEC;
            end
            default: n.st = ST_FETCH;
        endcase
        // timed source and discrete edges; a new event beats the clear
        n.d1 = discrete_irq_i;
        n.d2 = r.d1;
        n.d3 = r.d2;
        n.tsum = r.tsum + timer_incr_i;
        if (n.tsum >= timer_limit_i) begin
            n.tsum = 26'h0;
            n.irq_pend = 1'b1;
        end
        if (r.d2 && !r.d3) begin
            n.irq_pend = 1'b1;
        end
        if (!reset_n_i) begin
            n = '0;
            n.st = ST_FETCH;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        r <= n;
    end

    assign mem_rd_o = r.rd;
    assign mem_wr_o = r.wr;
    assign mem_sector_o = r.sect;
    assign mem_residual_o = r.res;
    assign mem_addr_o = r.addr;
    assign mem_wdata_o = r.wdata;
    assign mem_module_o = r.module_sel;
    assign mem_duplex_o = r.duplex;
    assign mem_err_clear_o = r.err_clr;
    assign io_out_o = r.io_out;
    assign io_addr_o = oa;
    assign io_wdata_o = r.wdata;
    assign acc_o = r.acc;
    assign pq_o = r.pq;
    assign md_busy_o = r.md_run;
    assign icount_o = r.icnt;

    property p_store_keeps_acc;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (r.st == ST_EXEC && op == gic_pkg::OP_STORE && !r.md_run) |=> mem_wr_o && mem_wdata_o == $past(r.acc);
    endproperty
    a_store_keeps_acc: assert property (p_store_keeps_acc) else $error("store failed");

    property p_hold_stalls;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (r.hold && r.st == ST_FETCH && !r.irq_pend) |=> !mem_rd_o;
    endproperty
    a_hold_stalls: assert property (p_hold_stalls) else $error("hold did not stall");

    property p_tmi_zero;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (r.st == ST_EXEC && op == gic_pkg::OP_TRANSFER_MINUS && !r.acc[25]) |=> $stable(r.icnt);
    endproperty
    a_tmi_zero: assert property (p_tmi_zero) else $error("minus branch on positive");

    property p_tra;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (r.st == ST_EXEC && op == gic_pkg::OP_UNCOND_XFER) |=> r.icnt == $past(oa[7:0]) && $stable(r.isect);
    endproperty
    a_tra: assert property (p_tra) else $error("transfer wrong");

    property p_irq_save;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (r.st == ST_IRQ_SAVE) |=> mem_wr_o && mem_residual_o && mem_addr_o == gic_pkg::RES_SAVE_WORD ##1 mem_rd_o && mem_addr_o == gic_pkg::RES_HOP_CONST;
    endproperty
    a_irq_save: assert property (p_irq_save) else $error("interrupt save wrong");

    property p_add;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (r.st == ST_EXEC && op == gic_pkg::OP_ADD && !(r.md_run && r.md_cnt == 32'h1)) |=> r.acc == $past(r.acc) + r.word;
    endproperty
    a_add: assert property (p_add) else $error("add wrong");

    property p_operand_space;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (r.st == ST_OPERAND) |=> mem_residual_o == $past(oa[8]) && mem_sector_o == r.dsect;
    endproperty
    a_operand_space: assert property (p_operand_space) else $error("operand space wrong");

    property p_md_stop;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (md_busy_o && r.md_cnt == 32'h1) |=> !md_busy_o;
    endproperty
    a_md_stop: assert property (p_md_stop) else $error("multiply did not stop");
endmodule
`default_nettype wire

// File: rtl/gic_pkg.sv
// package of constants for the guidance instruction control block
`default_nettype none
package gic_pkg;
    // opcodes
    localparam logic [3:0] OP_SECTOR_JUMP = 4'h0;
    localparam logic [3:0] OP_CONC_MPY = 4'h1;
    localparam logic [3:0] OP_SUBTRACT = 4'h2;
    localparam logic [3:0] OP_DIVIDE = 4'h3;
    localparam logic [3:0] OP_TRANSFER_NZ = 4'h4;
    localparam logic [3:0] OP_MPY_HOLD = 4'h5;
    localparam logic [3:0] OP_LOGICAL_AND = 4'h6;
    localparam logic [3:0] OP_ADD = 4'h7;
    localparam logic [3:0] OP_UNCOND_XFER = 4'h8;
    localparam logic [3:0] OP_PROCESS_IO = 4'h9;
    localparam logic [3:0] OP_XOR = 4'hA;
    localparam logic [3:0] OP_STORE = 4'hB;
    localparam logic [3:0] OP_TRANSFER_MINUS = 4'hC;
    localparam logic [3:0] OP_SHIFT = 4'hD;
    localparam logic [3:0] OP_CLEAR_LOAD = 4'hF;
    // residual words
    localparam logic [7:0] RES_PQ_WORD = 8'hFD;
    localparam logic [7:0] RES_HOP_CONST = 8'hFE;
    localparam logic [7:0] RES_SAVE_WORD = 8'hFF;
    // field layout of a sector-jump word
    localparam int SJ_ISECT_LSB = 0;
    localparam int SJ_ICNT_LSB = 4;
    localparam int SJ_SYL_BIT = 12;
    localparam int SJ_DSECT_LSB = 13;
    localparam int SJ_MOD_LSB = 17;
    localparam int SJ_DUPLEX_BIT = 20;
    localparam int SJ_ERRCLR_BIT = 21;
    // operand address fields
    localparam int OPB_ONE = 0;
    localparam int OPB_TWO = 1;
    localparam int OPB_FIVE = 4;
    localparam int OPB_SIX = 5;
    localparam int OPB_EIGHT = 7;
    localparam int OPB_NINE = 8;
    // timing
    localparam int CLK_MHZ = 250;
    localparam int CYCLE_US = 82;
    localparam int MPY_US = 328;
    localparam int MPH_US = 410;
    localparam int DIV_US = 656;
    localparam int CYCLE_CLKS = CYCLE_US * CLK_MHZ;
    localparam int MPY_CLKS = MPY_US * CLK_MHZ;
    localparam int MPH_CLKS = MPH_US * CLK_MHZ;
    localparam int DIV_CLKS = DIV_US * CLK_MHZ;
    localparam int MPY_SLOTS = 3;
    localparam int DIV_SLOTS = 7;
    localparam int WORD_W = 26;
    localparam int MD_W = 24;
endpackage
`default_nettype wire

// File: tb/gic_core_memory_model.sv
// core memory model facing the instruction control block
`default_nettype none
module gic_core_memory_model (
    input wire logic clk_i, // system clock
    input wire logic rd_i, // read strobe
    input wire logic wr_i, // write strobe
    input wire logic [3:0] sector_i, // sector select
    input wire logic residual_i, // residual memory select
    input wire logic [7:0] addr_i, // word address
    input wire logic [25:0] wdata_i, // write data
    output logic [25:0] rdata_o // read data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [25:0] sect_mem [16][256];
    logic [25:0] res_mem [256];
    initial begin
        rdata_o = 26'h0;
        foreach (sect_mem[s, a]) sect_mem[s][a] = 26'h0;
        foreach (res_mem[a]) res_mem[a] = 26'h0;
    end
    // data valid only in the cycle after the strobe, scrambled otherwise
    always @(posedge clk_i) begin
        if (rd_i) begin
            rdata_o <= residual_i ? res_mem[addr_i] : sect_mem[sector_i][addr_i];
        end else begin
            rdata_o <= ~rdata_o;
        end
        if (wr_i && residual_i) begin
            res_mem[addr_i] <= wdata_i;
        end else if (wr_i) begin
            sect_mem[sector_i][addr_i] <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// File: tb/test_gic_instruction_control.sv
// self-checking bench running small programs through the instruction control
`default_nettype none
module test_gic_instruction_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic discrete_irq_i = 1'b0;
    logic [25:0] io_rdata_i = 26'h2A5A5A5;
    logic [25:0] timer_incr = 26'h0;
    logic [25:0] timer_limit = 26'h3FFFFFF;
    logic mem_rd_o, mem_wr_o, mem_residual_o, mem_duplex_o, mem_err_clear_o;
    logic io_out_o, md_busy_o;
    logic [3:0] mem_sector_o;
    logic [7:0] mem_addr_o, icount_o;
    logic [2:0] mem_module_o;
    logic [8:0] io_addr_o;
    logic [25:0] mem_wdata_o, mem_rdata_i, io_wdata_o, acc_o, pq_o;
    logic [25:0] io_seen = 26'h0;
    logic [8:0] io_addr_seen = 9'h0;
    logic [25:0] save_word = 26'h0;
    logic clr_seen = 1'b0;
    logic busy_seen = 1'b0;
    logic save_seen = 1'b0;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    logic [12:0] p0 [27];
    logic [12:0] p2 [8];
    logic [12:0] p1 [3];

    gic_instruction_control #(.CYCLE_CLKS(8), .MPY_CLKS(20), .MPH_CLKS(25), .DIV_CLKS(40))
    dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o), .mem_sector_o(mem_sector_o), .mem_residual_o(mem_residual_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
        .mem_module_o(mem_module_o), .mem_duplex_o(mem_duplex_o),
        .mem_err_clear_o(mem_err_clear_o), .io_rdata_i(io_rdata_i), .io_out_o(io_out_o),
        .io_addr_o(io_addr_o), .io_wdata_o(io_wdata_o), .discrete_irq_i(discrete_irq_i),
        .timer_incr_i(timer_incr), .timer_limit_i(timer_limit), .acc_o(acc_o), .pq_o(pq_o),
        .md_busy_o(md_busy_o), .icount_o(icount_o));

    gic_core_memory_model mem_u (.clk_i(clk_sys_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
        .sector_i(mem_sector_o), .residual_i(mem_residual_o), .addr_i(mem_addr_o),
        .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // ----------------------------------------
    // monitors and hang guard
    // ----------------------------------------
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (io_out_o === 1'b1) begin
            io_seen <= io_wdata_o;
            io_addr_seen <= io_addr_o;
        end
        if (mem_err_clear_o === 1'b1) clr_seen <= 1'b1;
        if (md_busy_o === 1'b1) busy_seen <= 1'b1;
        if (mem_wr_o === 1'b1 && mem_residual_o === 1'b1 && mem_addr_o === 8'hFF) begin
            save_word <= mem_wdata_o;
            save_seen <= 1'b1;
        end
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [25:0] act, input logic [25:0] exp, input string what);
        check_count++;
        if (act !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, act, exp);
        end
    endtask

    task automatic put(input int s, input int idx, input logic [12:0] syl);
        if (idx % 2 == 0) mem_u.sect_mem[s][idx / 2][25:13] = syl;
        else mem_u.sect_mem[s][idx / 2][12:0] = syl;
    endtask

    function automatic logic [25:0] sj(input logic [3:0] is, input logic [7:0] ic);
        sj = 26'h0;
        sj[gic_pkg::SJ_ISECT_LSB +: 4] = is;
        sj[gic_pkg::SJ_ICNT_LSB +: 8] = ic;
        sj[gic_pkg::SJ_DSECT_LSB +: 4] = 4'h2;
        sj[gic_pkg::SJ_MOD_LSB +: 3] = 3'h3;
        sj[gic_pkg::SJ_DUPLEX_BIT] = 1'b1;
        sj[gic_pkg::SJ_ERRCLR_BIT] = 1'b1;
    endfunction

    // waits for a residual store to the given word, bounded
    task automatic wait_wr(input logic [7:0] a);
        int n;
        n = 0;
        while (!(mem_wr_o === 1'b1 && mem_residual_o === 1'b1 && mem_addr_o === a)
            && n < 3000) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        if (n >= 3000) check(26'h0, 26'h1, "store never seen");
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        p0 = '{{9'h110, gic_pkg::OP_CLEAR_LOAD}, {9'h111, gic_pkg::OP_ADD},
            {9'h140, gic_pkg::OP_STORE}, {9'h110, gic_pkg::OP_SUBTRACT},
            {9'h141, gic_pkg::OP_STORE}, {9'h112, gic_pkg::OP_LOGICAL_AND},
            {9'h112, gic_pkg::OP_XOR}, {9'h142, gic_pkg::OP_STORE},
            {9'h010, gic_pkg::OP_SHIFT}, {9'h002, gic_pkg::OP_SHIFT},
            {9'h143, gic_pkg::OP_STORE}, {9'h007, gic_pkg::OP_TRANSFER_NZ},
            {9'h111, gic_pkg::OP_CLEAR_LOAD}, {9'h144, gic_pkg::OP_STORE},
            {9'h111, gic_pkg::OP_SUBTRACT}, {9'h109, gic_pkg::OP_TRANSFER_MINUS},
            {9'h110, gic_pkg::OP_CLEAR_LOAD}, {9'h110, gic_pkg::OP_CLEAR_LOAD},
            {9'h110, gic_pkg::OP_CLEAR_LOAD}, {9'h144, gic_pkg::OP_STORE},
            {9'h113, gic_pkg::OP_CLEAR_LOAD}, {9'h001, gic_pkg::OP_TRANSFER_NZ},
            {9'h001, gic_pkg::OP_TRANSFER_MINUS}, {9'h082, gic_pkg::OP_PROCESS_IO},
            {9'h145, gic_pkg::OP_STORE}, {9'h081, gic_pkg::OP_PROCESS_IO},
            {9'h120, gic_pkg::OP_SECTOR_JUMP}};
        // product is never read, so no second multiply needs guarding
        p2 = '{{9'h030, gic_pkg::OP_CLEAR_LOAD}, {9'h146, gic_pkg::OP_STORE},
            {9'h110, gic_pkg::OP_CONC_MPY}, {9'h111, gic_pkg::OP_ADD},
            {9'h111, gic_pkg::OP_ADD}, {9'h111, gic_pkg::OP_ADD},
            {9'h147, gic_pkg::OP_STORE}, {9'h143, gic_pkg::OP_UNCOND_XFER}};
        // handler keeps no accumulator state worth restoring
        p1 = '{{9'h110, gic_pkg::OP_CLEAR_LOAD}, {9'h148, gic_pkg::OP_STORE},
            {9'h021, gic_pkg::OP_UNCOND_XFER}};
        #1;
        for (int i = 0; i < 27; i++) put(0, i, p0[i]);
        for (int i = 0; i < 8; i++) put(2, 8'h80 + i, p2[i]);
        for (int i = 0; i < 3; i++) put(1, 8'h40 + i, p1[i]);
        mem_u.res_mem[8'h10] = 26'h5;
        mem_u.res_mem[8'h11] = 26'h3;
        mem_u.res_mem[8'h12] = 26'h6;
        mem_u.res_mem[8'h20] = sj(4'h2, 8'h40);
        mem_u.res_mem[8'hFE] = sj(4'h1, 8'h20);
        mem_u.sect_mem[2][8'h30] = 26'h0123456;
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        wait_wr(8'h47);
        check(mem_u.res_mem[8'h40], 26'h8, "add");
        check(mem_u.res_mem[8'h41], 26'h3, "sub");
        check(mem_u.res_mem[8'h42], 26'h4, "and xor");
        check(mem_u.res_mem[8'h43], 26'h2, "shift");
        check(mem_u.res_mem[8'h44], 26'h3FFFFFF, "branches");
        check(mem_u.res_mem[8'h45], io_rdata_i, "io in");
        check(io_seen, io_rdata_i, "io out");
        check({17'h0, io_addr_seen}, 26'h081, "io addr");
        check(mem_u.res_mem[8'h46], 26'h0123456, "data sector");
        check({23'h0, mem_module_o}, 26'h3, "module");
        check({25'h0, mem_duplex_o}, 26'h1, "duplex");
        check({25'h0, clr_seen}, 26'h1, "error clear");
        check({25'h0, busy_seen}, 26'h1, "multiply busy");
        check(mem_u.res_mem[8'h47], 26'h012345F, "concurrent adds");
        $display("test program run done");
        @(posedge clk_sys_i);
        discrete_irq_i <= 1'b1;
        wait_wr(8'h48);
        discrete_irq_i <= 1'b0;
        check({25'h0, save_seen}, 26'h1, "state saved");
        check({22'h0, save_word[3:0]}, 26'h2, "saved sector");
        check(mem_u.res_mem[8'h48], 26'h5, "handler ran");
        $display("test interrupt done");
        timer_incr <= 26'h1;
        timer_limit <= 26'h40;
        wait_wr(8'h48);
        check({22'h0, save_word[3:0]}, 26'h1, "timed interrupt");
        $display("test timed interrupt done");
        complete_run();
    end
endmodule
`default_nettype wire
